// File: rtl/heartbeat_gen.sv
`timescale 1ns/1ps
// Blinking heartbeat; stops when not running so a hang is visible
module heartbeat_gen
	import illum_pkg::*;
#(
	parameter logic [HB_W-1:0] HALF_CYC = HB_W'(HB_HALF_CYC)
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	// Run status
	input wire logic running_i,
	// Indicator
	output logic heartbeat_o
);
	typedef struct packed {
		logic [HB_W-1:0] cnt;
		logic beat;
	} hb_state_t;
	hb_state_t st_ff; // Registered state
	hb_state_t nxt_st; // Next state

	// Count half periods, flip the indicator at each wrap
	always_comb begin
		nxt_st = st_ff;
		if (running_i) begin
			if (st_ff.cnt >= HALF_CYC - 1'b1) begin
				nxt_st.cnt = HB_RST;
				nxt_st.beat = ~st_ff.beat;
			end else begin
				nxt_st.cnt = st_ff.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign heartbeat_o = st_ff.beat;
endmodule : heartbeat_gen

// File: rtl/illum_pkg.sv
// Contract
// - Drive up to three independent light channels.
// - Each channel: enable output plus current PWM.
// - Any single enable may switch one source.
// - All enables may be held off.
// - Heartbeat toggles continuously while running normally.
// - Fault indicator off on fault, else on.
// - Exposure trigger high exactly during exposure.
// - Sequence start high during first pattern.
// - Step trigger advances or alternates two patterns.
// - Hold trigger pauses or advances by two.
// - Timing derives from one reference clock.
package illum_pkg;
	// Channel count and PWM resolution
	localparam int NUM_CHAN = 3;
	localparam int PWM_W = 8;
	localparam int IDX_W = 8;
	// Clock rate and derived timing
	localparam int CLK_MHZ = 250;
	localparam int REF_MHZ = 32;
	localparam int HB_HALF_MS = 250;
	localparam int HB_HALF_CYC = HB_HALF_MS * 1000 * CLK_MHZ;
	localparam int HB_W = 27;
	localparam logic [HB_W-1:0] HB_RST = 27'h0000000;
	// Reset values
	localparam logic [IDX_W-1:0] IDX_RST = 8'h00;
	localparam logic [PWM_W-1:0] PWM_RST = 8'h00;
	// Trigger interpretation mode
	typedef enum logic {
		TRIG_STEP_PAUSE,
		TRIG_ALTERNATE
	} trig_mode_t;
	localparam trig_mode_t TRIG_MODE_RST = TRIG_STEP_PAUSE;
endpackage : illum_pkg

// File: rtl/pattern_trigger_illumination.sv
`timescale 1ns/1ps
// Pattern sync triggers and illumination outputs.
// The sequencer reports exposure and first-pattern status; this block
// shapes the outward pins, steps the pattern index on triggers and
// drives the light source channels.
module pattern_trigger_illumination
	import illum_pkg::*;
#(
	parameter logic [HB_W-1:0] HB_HALF = HB_W'(HB_HALF_CYC)
) (
	// Clock (reference-derived) and reset
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	// Configuration
	input wire logic trig_mode_i,
	input wire logic [NUM_CHAN-1:0] chan_sel_i,
	input wire logic [PWM_W-1:0] chan0_duty_i,
	input wire logic [PWM_W-1:0] chan1_duty_i,
	input wire logic [PWM_W-1:0] chan2_duty_i,
	// Sequencer status
	input wire logic exposure_i,
	input wire logic first_pattern_i,
	input wire logic system_fault_i,
	// External processor triggers
	input wire logic step_trigger_in_i,
	input wire logic hold_trigger_in_i,
	// Light source driver
	output logic chan0_light_enable_o,
	output logic chan1_light_enable_o,
	output logic chan2_light_enable_o,
	output logic chan0_current_pwm_o,
	output logic chan1_current_pwm_o,
	output logic chan2_current_pwm_o,
	// Indicators
	output logic heartbeat_o,
	output logic fault_status_o,
	// Camera triggers
	output logic exposure_trigger_out_o,
	output logic sequence_start_out_o,
	// Pattern state
	output logic [IDX_W-1:0] pattern_index_o,
	output logic paused_o
);
	// Block state in one record; heartbeat and PWM flops sit in their instances
	typedef struct packed {
		trig_mode_t mode;
		logic step_d;
		logic hold_d;
		logic paused;
		logic alt_phase;
		logic [IDX_W-1:0] idx;
		logic [IDX_W-1:0] alt_base;
		logic [NUM_CHAN-1:0] en;
		logic fault_led;
		logic expo;
		logic seq_start;
		logic [PWM_W-1:0] pwm_cnt;
	} top_state_t;
	top_state_t st_ff; // Registered state
	top_state_t nxt_st; // Next state

	logic step_rise; // Rising edge of step trigger
	logic hold_rise; // Rising edge of hold trigger
	logic [NUM_CHAN-1:0] pwm_raw; // PWM from channel instances
	logic [PWM_W-1:0] duty [NUM_CHAN]; // Duty per channel

	assign duty[0] = chan0_duty_i;
	assign duty[1] = chan1_duty_i;
	assign duty[2] = chan2_duty_i;

	// Triggers are synchronous; act on the assertion edge only
	assign step_rise = step_trigger_in_i & ~st_ff.step_d;
	assign hold_rise = hold_trigger_in_i & ~st_ff.hold_d;

	// Next-state logic
	always_comb begin
		nxt_st = st_ff;
		nxt_st.step_d = step_trigger_in_i;
		nxt_st.hold_d = hold_trigger_in_i;
		// Mode only changes between triggers to avoid half-applied steps
		if (!step_rise && !hold_rise) begin
			nxt_st.mode = trig_mode_t'(trig_mode_i);
		end
		case (st_ff.mode)
			TRIG_STEP_PAUSE: begin
				// Hold toggles pause; a step while paused is ignored
				if (hold_rise) begin
					nxt_st.paused = ~st_ff.paused;
				end else if (step_rise && !st_ff.paused) begin
					nxt_st.idx = st_ff.idx + 1'b1;
					nxt_st.alt_base = st_ff.idx + 1'b1;
				end
			end
			TRIG_ALTERNATE: begin
				nxt_st.paused = 1'b0;
				// Hold wins over step when both arrive together
				if (hold_rise) begin
					nxt_st.alt_base = st_ff.alt_base + 8'h02;
					nxt_st.idx = st_ff.alt_base + 8'h02;
					nxt_st.alt_phase = 1'b0;
				end else if (step_rise) begin
					nxt_st.alt_phase = ~st_ff.alt_phase;
					nxt_st.idx = st_ff.alt_phase ? st_ff.alt_base
						: st_ff.alt_base + 1'b1;
				end
			end
			default: begin
				nxt_st.mode = TRIG_MODE_RST;
			end
		endcase
		// Enables follow exposure on selected channels; none selected
		// leaves the source to the outside processor
		nxt_st.en = chan_sel_i & {NUM_CHAN{exposure_i}};
		nxt_st.fault_led = ~system_fault_i;
		nxt_st.expo = exposure_i;
		nxt_st.seq_start = first_pattern_i;
		// Shared PWM timebase, free running on the one clock
		nxt_st.pwm_cnt = st_ff.pwm_cnt + 1'b1;
	end

	// State register
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_ff <= '0;
			st_ff.mode <= TRIG_MODE_RST;
			st_ff.idx <= IDX_RST;
			st_ff.alt_base <= IDX_RST;
			st_ff.pwm_cnt <= PWM_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// One PWM generator per channel, gated by its enable
	genvar g;
	generate
		for (g = 0; g < NUM_CHAN; g++) begin : g_chan
			logic [PWM_W-1:0] gated;
			assign gated = st_ff.en[g] ? duty[g] : PWM_RST;
			pwm_channel u_pwm (
				.sys_clk_i(sys_clk_i),
				.resetn_i(resetn_i),
				.duty_i(gated),
				.count_i(st_ff.pwm_cnt),
				.pwm_o(pwm_raw[g])
			);
		end
	endgenerate

	// Heartbeat runs only while no fault is present
	heartbeat_gen #(
		.HALF_CYC(HB_HALF)
	) u_hb (
		.sys_clk_i(sys_clk_i),
		.resetn_i(resetn_i),
		.running_i(st_ff.fault_led),
		.heartbeat_o(heartbeat_o)
	);

	// Outputs straight from flip-flops
	assign chan0_light_enable_o = st_ff.en[0];
	assign chan1_light_enable_o = st_ff.en[1];
	assign chan2_light_enable_o = st_ff.en[2];
	assign chan0_current_pwm_o = pwm_raw[0];
	assign chan1_current_pwm_o = pwm_raw[1];
	assign chan2_current_pwm_o = pwm_raw[2];
	assign fault_status_o = st_ff.fault_led;
	assign exposure_trigger_out_o = st_ff.expo;
	assign sequence_start_out_o = st_ff.seq_start;
	assign pattern_index_o = st_ff.idx;
	assign paused_o = st_ff.paused;
endmodule : pattern_trigger_illumination

// File: rtl/pwm_channel.sv
`timescale 1ns/1ps
// One channel's current PWM; output straight from a flip-flop
module pwm_channel
	import illum_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	// Duty and timebase
	input wire logic [PWM_W-1:0] duty_i,
	input wire logic [PWM_W-1:0] count_i,
	// Output
	output logic pwm_o
);
	typedef struct packed {
		logic pwm;
	} pwm_state_t;
	pwm_state_t st_ff; // Registered state
	pwm_state_t nxt_st; // Next state

	// High while counter below duty, so duty 0 is fully off
	always_comb begin
		nxt_st = st_ff;
		nxt_st.pwm = (count_i < duty_i);
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign pwm_o = st_ff.pwm;
endmodule : pwm_channel

// File: test/pti_properties.sv
`timescale 1ns/1ps
// Port-level timing checks for the trigger and illumination block
module pti_properties
	import illum_pkg::*;
#(
	parameter logic [HB_W-1:0] HB_HALF = HB_W'(HB_HALF_CYC)
) (
	// Clock, reset and inputs
	input wire logic sys_clk_i, resetn_i, trig_mode_i, exposure_i, first_pattern_i,
	input wire logic system_fault_i, step_trigger_in_i, hold_trigger_in_i,
	input wire logic [NUM_CHAN-1:0] chan_sel_i,
	// Outputs
	input wire logic chan0_light_enable_o, chan1_light_enable_o, chan2_light_enable_o,
	input wire logic chan0_current_pwm_o, chan1_current_pwm_o, chan2_current_pwm_o,
	input wire logic heartbeat_o, fault_status_o, exposure_trigger_out_o, sequence_start_out_o,
	input wire logic paused_o,
	input wire logic [IDX_W-1:0] pattern_index_o
);
	// Longest run-time gap between heartbeat flips, with two cycles of slack
	localparam logic [HB_W:0] BLINK_MAX = {1'b0, HB_HALF} + (HB_W + 1)'(2);
	logic [HB_W:0] since_flip_ff; // Running cycles since the heartbeat last moved
	logic hb_seen_ff; // Heartbeat one cycle ago
	// A counter stands in for a window far longer than a delay range may span
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			since_flip_ff <= '0;
			hb_seen_ff <= 1'b0;
		end else begin
			hb_seen_ff <= heartbeat_o;
			// A fault freezes the blink, so the count restarts
			if (heartbeat_o != hb_seen_ff || !fault_status_o) begin
				since_flip_ff <= '0;
			end else begin
				since_flip_ff <= since_flip_ff + 1'b1;
			end
		end
	end
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);
	AST_EXPO: assert property ($past(resetn_i) |-> exposure_trigger_out_o == $past(exposure_i))
		else $error("exposure out wrong");
	AST_START: assert property ($past(resetn_i) |-> sequence_start_out_o == $past(first_pattern_i))
		else $error("start out wrong");
	AST_FAULT: assert property ($past(resetn_i) |-> fault_status_o == !$past(system_fault_i))
		else $error("fault led wrong");
	AST_EN: assert property ($past(resetn_i) |-> {chan2_light_enable_o, chan1_light_enable_o,
		chan0_light_enable_o} == ($past(chan_sel_i) & {3{$past(exposure_i)}}))
		else $error("enables wrong");
	AST_PWM: assert property (!exposure_i [*4] |=> !(chan0_current_pwm_o | chan1_current_pwm_o
		| chan2_current_pwm_o))
		else $error("pwm outside exposure");
	AST_STEP: assert property ($rose(step_trigger_in_i) && !hold_trigger_in_i && !paused_o
		&& !trig_mode_i && !$past(trig_mode_i) |=> pattern_index_o == 8'($past(pattern_index_o) + 8'h01))
		else $error("step did not advance");
	AST_HOLD: assert property ($rose(hold_trigger_in_i) && !trig_mode_i && !$past(trig_mode_i)
		|=> paused_o != $past(paused_o))
		else $error("hold did not toggle pause");
	AST_BLINK: assert property (since_flip_ff <= BLINK_MAX)
		else $error("heartbeat stuck");
endmodule : pti_properties

bind pattern_trigger_illumination pti_properties #(.HB_HALF(HB_HALF)) chk_i (.*);

// File: test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import illum_pkg::*;
	logic sys_clk_i = 1'b0;
	logic resetn_i, trig_mode_i, exposure_i, first_pattern_i, system_fault_i;
	logic step_trigger_in_i, hold_trigger_in_i, heartbeat_o, fault_status_o;
	logic exposure_trigger_out_o, sequence_start_out_o, paused_o;
	logic [2:0] chan_sel_i, en, pwm;
	logic [7:0] chan0_duty_i, chan1_duty_i, chan2_duty_i, pattern_index_o;
	int err_total = 0, checked = 0, cycles = 0, a, b, n [3];
	// Rows: {sel, exposure, first, fault} beside {enables, exposure out, start out, fault led}
	logic [11:0] rows [6] = '{12'h30d, 12'hdb7, 12'h144, 12'he83, 12'h515, 12'h925};
	// Duty rows: {chan0, chan1, chan2}; high count over one period equals duty
	logic [23:0] duty_rows [2] = '{24'h4000ff, 24'h80017f};
	wire [5:0] obs = {en, exposure_trigger_out_o, sequence_start_out_o, fault_status_o};
	always #2 sys_clk_i = ~sys_clk_i;
	trig_proc_model proc (
		.sys_clk_i(sys_clk_i),
		.step_o(step_trigger_in_i),
		.hold_o(hold_trigger_in_i)
	);
	pattern_trigger_illumination #(.HB_HALF(27'h0000008)) dut (
		.sys_clk_i(sys_clk_i),
		.resetn_i(resetn_i),
		.trig_mode_i(trig_mode_i),
		.chan_sel_i(chan_sel_i),
		.chan0_duty_i(chan0_duty_i),
		.chan1_duty_i(chan1_duty_i),
		.chan2_duty_i(chan2_duty_i),
		.exposure_i(exposure_i),
		.first_pattern_i(first_pattern_i),
		.system_fault_i(system_fault_i),
		.step_trigger_in_i(step_trigger_in_i),
		.hold_trigger_in_i(hold_trigger_in_i),
		.chan0_light_enable_o(en[0]),
		.chan1_light_enable_o(en[1]),
		.chan2_light_enable_o(en[2]),
		.chan0_current_pwm_o(pwm[0]),
		.chan1_current_pwm_o(pwm[1]),
		.chan2_current_pwm_o(pwm[2]),
		.heartbeat_o(heartbeat_o),
		.fault_status_o(fault_status_o),
		.exposure_trigger_out_o(exposure_trigger_out_o),
		.sequence_start_out_o(sequence_start_out_o),
		.pattern_index_o(pattern_index_o),
		.paused_o(paused_o)
	);
	task automatic chk(input logic [15:0] got, exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int k);
		repeat (k) @(negedge sys_clk_i);
	endtask : cyc
	// Counts heartbeat changes over k cycles into a
	task automatic blinks(input int k);
		a = 0;
		repeat (k) begin
			b = heartbeat_o;
			cyc(1);
			a += int'(heartbeat_o != b);
		end
	endtask : blinks
	task automatic tally_and_finish;
		if (err_total == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : tally_and_finish
	// Hang guard, well beyond the few hundred cycles the run needs
	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			err_total++;
			tally_and_finish();
		end
	end
	initial begin
		{resetn_i, trig_mode_i, exposure_i, first_pattern_i, system_fault_i} = 5'h00;
		chan_sel_i = 3'h0;
		{chan0_duty_i, chan1_duty_i, chan2_duty_i} = duty_rows[0];
		cyc(8);
		resetn_i = 1;
		cyc(2);
		foreach (rows[i]) begin
			{chan_sel_i, exposure_i, first_pattern_i, system_fault_i} = rows[i][11:6];
			cyc(1);
			chk(16'(obs), 16'(rows[i][5:0]));
		end
		// Shared 256-cycle period: high count equals duty, for each duty row
		{chan_sel_i, exposure_i} = 4'hf;
		foreach (duty_rows[r]) begin
			{chan0_duty_i, chan1_duty_i, chan2_duty_i} = duty_rows[r];
			cyc(4);
			n = '{0, 0, 0};
			repeat (256) begin
				cyc(1);
				foreach (n[k]) n[k] += int'(pwm[k]);
			end
			foreach (n[k]) chk(16'(n[k]), 16'(duty_rows[r][23 - 8 * k -: 8]));
		end
		blinks(64);
		chk(16'(a), 16'h0008);
		system_fault_i = 1;
		cyc(4);
		blinks(16);
		chk(16'({a[7:0], fault_status_o}), 16'h0000);
		system_fault_i = 0;
		proc.pulse(0);
		chk(16'(pattern_index_o), 16'h0001);
		proc.pulse(1);
		proc.pulse(0);
		chk(16'({paused_o, pattern_index_o}), 16'h0101);
		proc.pulse(1);
		proc.pulse(0);
		chk(16'({paused_o, pattern_index_o}), 16'h0002);
		trig_mode_i = 1;
		cyc(3);
		proc.pulse(0);
		a = pattern_index_o;
		proc.pulse(0);
		b = pattern_index_o;
		proc.pulse(0);
		chk(16'(a), 16'(b + 1));
		chk(16'(pattern_index_o), 16'(b + 1));
		proc.pulse(1);
		chk(16'(pattern_index_o), 16'(b + 2));
		proc.pulse(0);
		chk(16'(pattern_index_o), 16'(b + 3));
		trig_mode_i = 0;
		resetn_i = 0;
		cyc(1);
		chk(16'({pattern_index_o, en, exposure_trigger_out_o}), 16'h0000);
		resetn_i = 1;
		proc.pulse(0);
		chk(16'(pattern_index_o), 16'h0001);
		tally_and_finish();
	end
endmodule : tb_top

// File: test/trig_proc_model.sv
`timescale 1ns/1ps
// Outside processor: one-cycle trigger pulses, each followed by a low cycle
module trig_proc_model (
	input wire logic sys_clk_i,
	output logic step_o = 1'b0,
	output logic hold_o = 1'b0
);
	// Low cycle after each pulse keeps rises at least two cycles apart
	task automatic pulse(input bit which);
		@(negedge sys_clk_i);
		if (which) hold_o = 1'b1;
		else step_o = 1'b1;
		@(negedge sys_clk_i);
		{step_o, hold_o} = 2'h0;
		@(negedge sys_clk_i);
	endtask : pulse
endmodule : trig_proc_model
